// *** adc_cfg_pkg.sv ***
/*
  constants, field positions, codes and carrier types shared by the
  converter configuration block.
  assumes a 16-bit serial frame sent msb first.
*/
`default_nettype none
package adc_cfg_pkg;

  // frame shape
  localparam int FRAME_LEN       = 16;
  localparam int CNT_W           = 5;
  localparam int RANGE_LOAD_EDGE = 11;
  localparam int CTRL_LOAD_EDGE  = 15;

  // header bits, numbered 15..0 from the msb
  localparam int HDR_WRITE_POS   = 15;
  localparam int HDR_ZERO_POS    = 14;
  localparam int HDR_SEL_POS     = 13;

  // control word fields, numbered 15..0
  localparam int CTRL_ADDR_POS   = 10;
  localparam int CTRL_REF_POS    = 4;
  localparam int CTRL_SEQ_HI_POS = 3;
  localparam int CTRL_SEQ_LO_POS = 2;

  // range word fields, numbered 16..1 from the msb
  localparam int RNG_CH0_HI_POS  = 13;
  localparam int RNG_CH0_LO_POS  = 12;
  localparam int RNG_CH1_HI_POS  = 9;
  localparam int RNG_CH1_LO_POS  = 8;

  // reference buffer settling
  localparam int REF_SETTLE_US   = 500;
  localparam int SYS_CLK_MHZ     = 250;
  localparam int REF_SETTLE_CYC  = REF_SETTLE_US * SYS_CLK_MHZ;

  typedef enum logic [1:0] {
    RANGE_BIP_10V  = 2'h0,
    RANGE_BIP_5V   = 2'h1,
    RANGE_BIP_2V5  = 2'h2,
    RANGE_UNI_10V  = 2'h3
  } range_t;

  localparam range_t RANGE_RESET = RANGE_BIP_10V;
  localparam logic   REF_RESET   = 1'h0;

  typedef enum logic {
    SEQ_SINGLE = 1'h0,
    SEQ_SWEEP  = 1'h1
  } seq_state_t;

  typedef struct packed {
    logic ref_int;
    logic channel_addr_bit;
    logic sweep_ctl_hi;
    logic sweep_ctl_lo;
  } ctrl_word_t;

  typedef struct packed {
    range_t ch1;
    range_t ch0;
  } range_word_t;

endpackage
`default_nettype wire

// *** sync_2ff.sv ***
/*
  two flip-flop level synchroniser, one stage pair per bit.
  assumes each input bit is a level from another clock or a pin.
*/
`timescale 1ns/1ns
`default_nettype none
module sync_2ff #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t s_r;
  sync_state_t s_nxt;

  always_comb begin
    s_nxt        = s_r;
    s_nxt.meta   = async_in;
    s_nxt.stable = s_r.meta;
  end

  // each bit resets to its source's idle level: no false edge after reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= {RESET_VAL, RESET_VAL};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_out = s_r.stable;

endmodule
`default_nettype wire

// *** adc_seq_range_cfg.sv ***
/*
  serial configuration, range store and channel sequencer of a
  two-channel converter.
  assumes the host drives serial_clk, cs_n and din, that serial_clk
  stands still while cs_n is high, and that every frame is 16 clocks.
*/
// What this block does
// - seq bits 00: convert addressed channel; 01 or 11 keep the current mode
// - seq bits 10: sweep channel 0 to the addressed channel
// - sweep uses each channel's stored range
// - sweep ends only on seq bits 00
// - range store is 4-bit, write-only
// - range frame: write 1, zero 0, select 1
// - range bits at positions 13,12 and 9,8
// - range codes 00,01,10,11 select four ranges
// - ranges reset to code 00
// - selected channel gets its range automatically
// - reference bit resets 0; 1 selects internal
// - control bits at 3, 2, 10, 4
// - three msbs pick control or range
// - sample falling edges; range loads edge 11
`timescale 1ns/1ns
`default_nettype none
module adc_seq_range_cfg #(
  parameter int CHANNELS          = 2,
  parameter int REF_SETTLE_CYCLES = adc_cfg_pkg::REF_SETTLE_CYC
) (
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic                  serial_clk,
  input  wire logic                  cs_n,
  input  wire logic                  din,
  output logic                       conv_start,
  output logic                       conv_channel,
  output adc_cfg_pkg::range_t        conv_range,
  output logic                       conv_ref_int,
  output adc_cfg_pkg::range_word_t   channel_ranges,
  output logic                       ref_int_sel,
  output logic                       ref_ready,
  output logic                       sweep_active
);

  localparam int SET_W = $clog2(REF_SETTLE_CYCLES + 1);

  // =========================================================
  // link side: frame shift and bit count
  // =========================================================
  typedef struct packed {
    logic [adc_cfg_pkg::FRAME_LEN-1:0] shift;
    logic [adc_cfg_pkg::CNT_W-1:0]     count;
  } frame_state_t;

  typedef struct packed {
    adc_cfg_pkg::range_word_t rng;
    adc_cfg_pkg::ctrl_word_t  ctrl;
    logic                     rng_tgl;
    logic                     ctl_tgl;
  } hold_state_t;

  frame_state_t fr_r;
  frame_state_t fr_nxt;
  hold_state_t  hd_r;
  hold_state_t  hd_nxt;

  logic [adc_cfg_pkg::FRAME_LEN-1:0] sh_now;
  logic [adc_cfg_pkg::CNT_W-1:0]     edge_num;
  logic                              at_range_edge;
  logic                              at_ctrl_edge;
  logic                              hdr_range;
  logic                              hdr_ctrl;

  // frame bit b, msb numbered 15, sits at index b-(16-edge)
  function automatic int rng_idx(input int pos16);
    rng_idx = pos16 - 1
            - (adc_cfg_pkg::FRAME_LEN - adc_cfg_pkg::RANGE_LOAD_EDGE);
  endfunction

  function automatic int ctl_idx(input int pos);
    ctl_idx = pos
            - (adc_cfg_pkg::FRAME_LEN - adc_cfg_pkg::CTRL_LOAD_EDGE);
  endfunction

  always_comb begin
    fr_nxt   = fr_r;
    sh_now   = {fr_r.shift[adc_cfg_pkg::FRAME_LEN-2:0], din};
    edge_num = fr_r.count + 5'h01;
    fr_nxt.shift = sh_now;
    if (fr_r.count != adc_cfg_pkg::CNT_W'(adc_cfg_pkg::FRAME_LEN)) begin
      fr_nxt.count = edge_num;
    end
  end

  // counter restarts whenever chip select is high
  always_ff @(negedge serial_clk or posedge reset or posedge cs_n) begin
    if (reset || cs_n) begin
      fr_r <= '0;
    end else begin
      fr_r <= fr_nxt;
    end
  end

  // =========================================================
  // link side: register decode and load
  // =========================================================
  always_comb begin
    hd_nxt        = hd_r;
    at_range_edge = (fr_r.count == adc_cfg_pkg::CNT_W'(
                     adc_cfg_pkg::RANGE_LOAD_EDGE - 1));
    at_ctrl_edge  = (fr_r.count == adc_cfg_pkg::CNT_W'(
                     adc_cfg_pkg::CTRL_LOAD_EDGE - 1));
    hdr_range = 1'h0;
    hdr_ctrl  = 1'h0;
    if (at_range_edge) begin
      hdr_range = sh_now[rng_idx(adc_cfg_pkg::HDR_WRITE_POS + 1)]
                & ~sh_now[rng_idx(adc_cfg_pkg::HDR_ZERO_POS + 1)]
                & sh_now[rng_idx(adc_cfg_pkg::HDR_SEL_POS + 1)];
    end
    if (at_ctrl_edge) begin
      hdr_ctrl = sh_now[ctl_idx(adc_cfg_pkg::HDR_WRITE_POS)]
               & ~sh_now[ctl_idx(adc_cfg_pkg::HDR_ZERO_POS)]
               & ~sh_now[ctl_idx(adc_cfg_pkg::HDR_SEL_POS)];
    end
    if (hdr_range) begin
      hd_nxt.rng.ch0 = adc_cfg_pkg::range_t'({
        sh_now[rng_idx(adc_cfg_pkg::RNG_CH0_HI_POS)],
        sh_now[rng_idx(adc_cfg_pkg::RNG_CH0_LO_POS)]});
      hd_nxt.rng.ch1 = adc_cfg_pkg::range_t'({
        sh_now[rng_idx(adc_cfg_pkg::RNG_CH1_HI_POS)],
        sh_now[rng_idx(adc_cfg_pkg::RNG_CH1_LO_POS)]});
      hd_nxt.rng_tgl = ~hd_r.rng_tgl;
    end
    if (hdr_ctrl) begin
      hd_nxt.ctrl.channel_addr_bit =
        sh_now[ctl_idx(adc_cfg_pkg::CTRL_ADDR_POS)];
      hd_nxt.ctrl.ref_int =
        sh_now[ctl_idx(adc_cfg_pkg::CTRL_REF_POS)];
      hd_nxt.ctrl.sweep_ctl_hi =
        sh_now[ctl_idx(adc_cfg_pkg::CTRL_SEQ_HI_POS)];
      hd_nxt.ctrl.sweep_ctl_lo =
        sh_now[ctl_idx(adc_cfg_pkg::CTRL_SEQ_LO_POS)];
      hd_nxt.ctl_tgl = ~hd_r.ctl_tgl;
    end
  end

  always_ff @(negedge serial_clk or posedge reset) begin
    if (reset) begin
      hd_r.rng.ch0 <= adc_cfg_pkg::RANGE_RESET;
      hd_r.rng.ch1 <= adc_cfg_pkg::RANGE_RESET;
      hd_r.ctrl    <= '0;
      hd_r.rng_tgl <= 1'h0;
      hd_r.ctl_tgl <= 1'h0;
    end else begin
      hd_r <= hd_nxt;
    end
  end

  // =========================================================
  // crossing into the system clock
  // =========================================================
  logic [2:0] sync_q;
  logic       cs_n_s;
  logic       rng_tgl_s;
  logic       ctl_tgl_s;

  sync_2ff #(
    .WIDTH     (3),
    .RESET_VAL (3'h4)
  ) u_sync (
    .clk       (sys_clk),
    .reset     (reset),
    .async_in  ({cs_n, hd_r.rng_tgl, hd_r.ctl_tgl}),
    .sync_out  (sync_q)
  );

  assign cs_n_s    = sync_q[2];
  assign rng_tgl_s = sync_q[1];
  assign ctl_tgl_s = sync_q[0];

  // =========================================================
  // system side: stored configuration and sequencer
  // =========================================================
  typedef struct packed {
    logic                     cs_n_d;
    logic                     rng_tgl_d;
    logic                     ctl_tgl_d;
    adc_cfg_pkg::range_word_t rng;
    adc_cfg_pkg::ctrl_word_t  ctrl;
    adc_cfg_pkg::seq_state_t  mode;
    logic                     ptr;
    logic                     conv_start;
    logic                     conv_channel;
    adc_cfg_pkg::range_t      conv_range;
    logic                     conv_ref_int;
    logic [SET_W-1:0]         settle;
    logic                     ref_ready;
  } sys_state_t;

  sys_state_t st_r;
  sys_state_t st_nxt;
  logic       conv_evt;
  logic       next_ch;

  always_comb begin
    st_nxt            = st_r;
    st_nxt.cs_n_d     = cs_n_s;
    st_nxt.rng_tgl_d  = rng_tgl_s;
    st_nxt.ctl_tgl_d  = ctl_tgl_s;
    st_nxt.conv_start = 1'h0;
    conv_evt          = st_r.cs_n_d & ~cs_n_s;
    next_ch           = st_r.ctrl.channel_addr_bit;

    // link words are stable long before the toggle arrives
    if (rng_tgl_s != st_r.rng_tgl_d) begin
      st_nxt.rng = hd_r.rng;
    end
    if (ctl_tgl_s != st_r.ctl_tgl_d) begin
      st_nxt.ctrl = hd_r.ctrl;
      if (hd_r.ctrl.sweep_ctl_hi && !hd_r.ctrl.sweep_ctl_lo) begin
        if (st_r.mode == adc_cfg_pkg::SEQ_SINGLE) begin
          st_nxt.ptr = 1'h0;
        end
        st_nxt.mode = adc_cfg_pkg::SEQ_SWEEP;
      end else if (!hd_r.ctrl.sweep_ctl_hi
                   && !hd_r.ctrl.sweep_ctl_lo) begin
        st_nxt.mode = adc_cfg_pkg::SEQ_SINGLE;
      end else if (st_r.mode == adc_cfg_pkg::SEQ_SINGLE) begin
        st_nxt.mode = adc_cfg_pkg::SEQ_SINGLE;
      end
    end

    // conversion start picks channel, range and reference
    if (conv_evt) begin
      unique case (st_r.mode)
        adc_cfg_pkg::SEQ_SWEEP: begin
          next_ch = st_r.ptr;
          if (st_r.ptr == st_r.ctrl.channel_addr_bit) begin
            st_nxt.ptr = 1'h0;
          end else begin
            st_nxt.ptr = st_r.ptr + 1'h1;
          end
        end
        adc_cfg_pkg::SEQ_SINGLE: begin
          next_ch = st_r.ctrl.channel_addr_bit;
        end
      endcase
      st_nxt.conv_start   = 1'h1;
      st_nxt.conv_channel = next_ch;
      st_nxt.conv_range   = next_ch ? st_r.rng.ch1 : st_r.rng.ch0;
      st_nxt.conv_ref_int = st_r.ctrl.ref_int;
    end

    // internal reference settling time
    if (!st_r.ctrl.ref_int) begin
      st_nxt.settle    = SET_W'(REF_SETTLE_CYCLES);
      st_nxt.ref_ready = 1'h1;
    end else if (st_r.settle != '0) begin
      st_nxt.settle    = st_r.settle - 1'h1;
      st_nxt.ref_ready = 1'h0;
    end else begin
      st_nxt.ref_ready = 1'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_r.cs_n_d       <= 1'h1;
      st_r.rng_tgl_d    <= 1'h0;
      st_r.ctl_tgl_d    <= 1'h0;
      st_r.rng.ch0      <= adc_cfg_pkg::RANGE_RESET;
      st_r.rng.ch1      <= adc_cfg_pkg::RANGE_RESET;
      st_r.ctrl         <= '0;
      st_r.ctrl.ref_int <= adc_cfg_pkg::REF_RESET;
      st_r.mode         <= adc_cfg_pkg::SEQ_SINGLE;
      st_r.ptr          <= 1'h0;
      st_r.conv_start   <= 1'h0;
      st_r.conv_channel <= 1'h0;
      st_r.conv_range   <= adc_cfg_pkg::RANGE_RESET;
      st_r.conv_ref_int <= adc_cfg_pkg::REF_RESET;
      st_r.settle       <= SET_W'(REF_SETTLE_CYCLES);
      st_r.ref_ready    <= 1'h1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // =========================================================
  // outputs
  // =========================================================
  assign conv_start     = st_r.conv_start;
  assign conv_channel   = st_r.conv_channel;
  assign conv_range     = st_r.conv_range;
  assign conv_ref_int   = st_r.conv_ref_int;
  assign channel_ranges = st_r.rng;
  assign ref_int_sel    = st_r.ctrl.ref_int;
  assign ref_ready      = st_r.ref_ready;
  assign sweep_active   = (st_r.mode == adc_cfg_pkg::SEQ_SWEEP);

endmodule
`default_nettype wire

// *** host_link_model.sv ***
/*
  host side of the serial link: sends msb-first frames.
  assumes the bench calls xfer one frame at a time.
*/
`timescale 1ns/1ns
`default_nettype none
module host_link_model (
  output logic serial_clk,
  output logic cs_n,
  output logic din
);
  initial begin
    serial_clk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // ====
  // frame; a short count raises cs_n early
  task automatic xfer(input logic [15:0] w, input int nbits);
    #7 cs_n = 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      din = w[i];
      #63 serial_clk = 1'b0;
      #62 serial_clk = 1'b1;
    end
    #20 cs_n = 1'b1;
    din = ~din;
    #400;
  endtask
endmodule
`default_nettype wire

// *** adc_seq_range_cfg_monitor.sv ***
/*
  checker on the configuration block ports.
  assumes conversions are whole serial frames apart.
*/
`timescale 1ns/1ns
`default_nettype none
module adc_seq_range_cfg_monitor (
  input wire logic                     sys_clk,
  input wire logic                     reset,
  input wire logic                     cs_n,
  input wire logic                     conv_start,
  input wire logic                     conv_channel,
  input wire adc_cfg_pkg::range_t      conv_range,
  input wire logic                     conv_ref_int,
  input wire adc_cfg_pkg::range_word_t channel_ranges,
  input wire logic                     ref_int_sel,
  input wire logic                     ref_ready,
  input wire logic                     sweep_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // previous conversion's channel and mode
  logic prev_ch_r;
  logic prev_sw_r;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prev_ch_r <= 1'h0;
      prev_sw_r <= 1'h0;
    end else if (conv_start) begin
      prev_ch_r <= conv_channel;
      prev_sw_r <= sweep_active;
    end
  end
  // ====
  // assertions
  property p_rst_vals;
    disable iff (1'b0) reset |-> channel_ranges == 4'h0 && !ref_int_sel
      && ref_ready && !sweep_active;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("reset values wrong");
  property p_pulse;
    conv_start |=> !conv_start;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("start pulse too long");
  property p_cause;
    conv_start |-> !$past(cs_n) && ($past(cs_n, 4) || $past(cs_n, 5));
  endproperty
  a_cause: assert property (p_cause)
    else $error("start without select fall");
  property p_rng;
    conv_start |-> conv_range ==
      (conv_channel ? channel_ranges.ch1 : channel_ranges.ch0);
  endproperty
  a_rng: assert property (p_rng)
    else $error("range not the channel's");
  property p_ref;
    conv_start |-> conv_ref_int == ref_int_sel;
  endproperty
  a_ref: assert property (p_ref)
    else $error("reference not the selected one");
  property p_hold;
    !conv_start |-> $stable(conv_channel) && $stable(conv_range)
      && $stable(conv_ref_int);
  endproperty
  a_hold: assert property (p_hold)
    else $error("conversion setup moved");
  property p_first;
    conv_start && sweep_active && !prev_sw_r |-> !conv_channel;
  endproperty
  a_first: assert property (p_first)
    else $error("sweep not from channel 0");
  property p_wrap;
    conv_start && sweep_active && prev_sw_r && prev_ch_r |-> !conv_channel;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("sweep did not wrap");
  property p_quiet;
    cs_n [*8] |=> $stable(channel_ranges) && $stable(sweep_active);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("store changed outside frame");
  property p_drop;
    $rose(ref_int_sel) |-> ##[0:1] !ref_ready;
  endproperty
  a_drop: assert property (p_drop)
    else $error("ready kept on reference enable");
  c_sweep: cover property (conv_start && sweep_active);
  c_ch1: cover property (conv_start && conv_channel);
  c_settle: cover property (!ref_ready);
endmodule
bind adc_seq_range_cfg adc_seq_range_cfg_monitor u_mon (
  .sys_clk, .reset, .cs_n, .conv_start, .conv_channel, .conv_range,
  .conv_ref_int, .channel_ranges, .ref_int_sel, .ref_ready, .sweep_active
);
`default_nettype wire

// *** adc_seq_range_cfg_tb.sv ***
/*
  self-checking bench for the configuration block.
  assumes the host model and the bound checker.
*/
`timescale 1ns/1ns
`default_nettype none
module adc_seq_range_cfg_tb;
  logic                     sys_clk;
  logic                     reset;
  logic                     serial_clk;
  logic                     cs_n;
  logic                     din;
  logic                     conv_start;
  logic                     conv_channel;
  adc_cfg_pkg::range_t      conv_range;
  logic                     conv_ref_int;
  adc_cfg_pkg::range_word_t channel_ranges;
  logic                     ref_int_sel;
  logic                     ref_ready;
  logic                     sweep_active;
  int                       n_fail = 0;
  int                       samples_checked = 0;
  int                       cyc = 0;
  int                       n_start = 0;
  host_link_model host (.serial_clk, .cs_n, .din);
  adc_seq_range_cfg #(.REF_SETTLE_CYCLES(200)) uut (
    .sys_clk, .reset, .serial_clk, .cs_n, .din, .conv_start,
    .conv_channel, .conv_range, .conv_ref_int, .channel_ranges,
    .ref_int_sel, .ref_ready, .sweep_active
  );
  // ====
  // helpers
  task automatic end_sim;
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic fr(input logic [15:0] w);
    host.xfer(w, 16);
  endtask
  task automatic idle;
    fr(16'h0000);
  endtask
  // ====
  // scenarios
  task automatic t_reset;
    chk(channel_ranges, 4'h0);
    chk({2'h0, ref_int_sel, ref_ready}, 4'h1);
    chk({3'h0, sweep_active}, 4'h0);
    idle();
    chk({1'h0, conv_ref_int, conv_range}, 4'h0);
    chk(4'(n_start), 4'h1);
  endtask
  task automatic t_range;
    for (int c = 0; c < 4; c++) begin
      fr(16'ha000 | 16'(c) << 11 | 16'(3 - c) << 7);
      chk(channel_ranges, 4'(((3 - c) << 2) | c));
    end
    fr(16'h8400);
    idle();
    chk({1'h0, conv_channel, conv_range}, 4'h4);
    fr(16'h800c);
    idle();
    chk({1'h0, conv_channel, conv_range}, 4'h3);
  endtask
  task automatic t_refused;
    fr(16'h2800);
    fr(16'he800);
    host.xfer(16'ha800, 10);
    chk(channel_ranges, 4'h3);
    host.xfer(16'ha880, 11);
    chk(channel_ranges, 4'h5);
  endtask
  task automatic t_sweep;
    fr(16'hb180);
    fr(16'h8408);
    chk({3'h0, sweep_active}, 4'h1);
    for (int i = 0; i < 4; i++) begin
      idle();
      chk({1'h0, conv_channel, conv_range}, (i % 2) ? 4'h7 : 4'h2);
    end
    fr(16'h840c);
    chk({3'h0, sweep_active}, 4'h1);
    fr(16'h8400);
    chk({3'h0, sweep_active}, 4'h0);
    idle();
    chk({1'h0, conv_channel, conv_range}, 4'h7);
  endtask
  task automatic t_ref;
    fr(16'h8010);
    chk({2'h0, ref_int_sel, ref_ready}, 4'h2);
    repeat (200) @(posedge sys_clk);
    #1;
    chk({3'h0, ref_ready}, 4'h1);
    idle();
    chk({3'h0, conv_ref_int}, 4'h1);
  endtask
  // ====
  // clock, reset, sequence, timeout
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    reset = 1'b0;
    #1 reset = 1'b1;
    repeat (20) @(posedge sys_clk);
    #1 reset = 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_range();
    t_refused();
    t_sweep();
    t_ref();
    end_sim();
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      end_sim();
    end
  end
  // count start pulses mid-cycle, away from the launching edge
  always @(negedge sys_clk) begin
    if (conv_start === 1'b1) begin
      n_start++;
    end
  end
endmodule
`default_nettype wire
